// File: design/remote_local_mode_control.sv
// Purpose: Remote/local mode control with a serial command link and APB status
// Assumes: 10 MHz pclk; straps read high when closed; button high when pressed
// Notes:   One line per command, first character is the opcode, CR executes it
//
// How it works
// RQ1: Remote permit is set after power-up
// RQ2: Any command in local with permit enters remote, except go-local and permit-off
// RQ3: Entering remote forces output off until on-command
// RQ4: Local button returns to local unless locked out
// RQ5: Lockout command makes the button ignored
// RQ6: Go-local enters local, lockout kept
// RQ7: Permit-off clears lockout, permit, enters local
// RQ8: Permit query reports the present flag
// RQ9: Serial frames are 8N1, full duplex
// RQ10: Bit rate 75 to 9600, default 9600
// RQ11: Flow control software, hardware or none
// RQ12: Carriage return ends and executes a command
// RQ13: Trip level from software in remote, panel in local
// RQ14: Default trip level is 110 percent
// RQ15: Two straps pick the trip-level source
// RQ16: Strap selects shutdown input polarity
// RQ17: Shutdown disables only the supply output
// RQ18: Local mode takes settings from the front panel
// RQ19: Software flow sends 0x13 when full
// RQ20: Software flow sends 0x11 when ready again
// RQ21: Button and shutdown are synchronised and debounced
`include "rlm_defs.svh"
module remote_local_mode_control #(
  parameter int unsigned BIT_CYCLES_MIN  = `BIT_CYCLES_MIN,
  parameter int unsigned DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  rlm_pkg::apb_req_s apb_req,
  output rlm_pkg::apb_rsp_s apb_rsp,
  input  wire logic        rxd,
  output logic             txd,
  output logic             ready_out,
  input  wire logic        local_button,
  input  wire logic        shutdown_in,
  input  wire logic        local_trip_strap,
  input  wire logic        remote_trip_strap,
  input  wire logic        shutdown_polarity_strap,
  output logic             remote_mode,
  output logic             supply_output_on,
  output logic             trip_from_software,
  output logic [7:0]       soft_trip_level,
  output logic             panel_settings
);
  import rlm_pkg::*;

  state_s            q;
  state_s            n;
  logic [`CNT_W-1:0] period;
  logic              rx_valid;
  logic              exec;
  logic              enter;
  logic              rem_now;
  logic              btn_rise;
  logic              sd_active;
  logic              busy;
  logic              apb_done;

  // Cycles of one bit: rates are 75 doubled sel times
  function automatic logic [`CNT_W-1:0] bit_period(input logic [2:0] sel);
    logic [31:0] p;
    p = BIT_CYCLES_MIN >> sel;
    return p[`CNT_W-1:0];
  endfunction

  // Debounce step: returns {counter, level}
  function automatic logic [`DEB_W:0] debounce(input logic raw, input logic lvl, input logic [`DEB_W-1:0] cnt);
    logic [31:0] lim;
    lim = DEBOUNCE_CYCLES - 1;
    if (raw == lvl) begin
      return {{`DEB_W{1'b0}}, lvl};
    end else if (cnt == lim[`DEB_W-1:0]) begin
      return {{`DEB_W{1'b0}}, raw};
    end
    return {cnt + 1'b1, lvl};
  endfunction

  // Next-state logic of the whole block
  always_comb begin
    n         = q;
    period    = bit_period(q.baud_sel); // RQ10
    rx_valid  = 1'b0;
    exec      = 1'b0;
    enter     = 1'b0;
    rem_now   = q.remote;
    busy      = q.line_len >= `LINE_HIGH;
    apb_done  = apb_req.psel && apb_req.penable && q.rsp.pready;

    // Three-stage synchronisers, a change counts when stages two and three agree
    n.s1 = {shutdown_polarity_strap, remote_trip_strap, local_trip_strap, shutdown_in, local_button, rxd};
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int i = 0; i < 6; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        n.stab[i] = q.s3[i];
      end
    end

    // Debounce of button and shutdown input
    {n.btn_cnt, n.btn_db} = debounce(q.stab[1], q.btn_db, q.btn_cnt); // RQ21
    {n.sd_cnt, n.sd_db}   = debounce(q.stab[2], q.sd_db, q.sd_cnt);   // RQ21
    btn_rise  = n.btn_db && !q.btn_db;
    sd_active = q.stab[5] ? q.sd_db : !q.sd_db; // RQ16

    // Receiver: start, eight data bits LSB first, one stop bit
    unique case (q.rx_st)
      RX_IDLE: begin
        if (!q.stab[0]) begin
          n.rx_st  = RX_START;
          n.rx_cnt = period >> 1;
        end
      end
      RX_START: begin
        if (q.rx_cnt == '0) begin
          n.rx_st  = q.stab[0] ? RX_IDLE : RX_DATA;
          n.rx_cnt = period - 1'b1;
          n.rx_bit = 3'h0;
        end else begin
          n.rx_cnt = q.rx_cnt - 1'b1;
        end
      end
      RX_DATA: begin
        if (q.rx_cnt == '0) begin
          n.rx_sh  = {q.stab[0], q.rx_sh[7:1]}; // RQ9
          n.rx_cnt = period - 1'b1;
          n.rx_bit = q.rx_bit + 1'b1;
          if (q.rx_bit == 3'h7) begin
            n.rx_st = RX_STOP;
          end
        end else begin
          n.rx_cnt = q.rx_cnt - 1'b1;
        end
      end
      RX_STOP: begin
        if (q.rx_cnt == '0) begin
          n.rx_st  = RX_IDLE;
          rx_valid = q.stab[0]; // RQ9
        end else begin
          n.rx_cnt = q.rx_cnt - 1'b1;
        end
      end
    endcase

    // Line assembly; characters past the limit are dropped
    if (rx_valid) begin
      if (q.rx_sh == `CHAR_CR) begin
        exec       = q.line_len != 5'h00; // RQ12
        n.line_len = 5'h00;
      end else if (q.line_len < `LINE_MAX) begin
        if (q.line_len == 5'h00) begin
          n.op = q.rx_sh;
        end
        if (q.line_len == 5'h01) begin
          n.arg = q.rx_sh;
        end
        n.line_len = q.line_len + 1'b1;
      end
    end

    // Transmitter: pick next character, flow characters first
    if (q.tx_left == 4'h0) begin
      if (q.xoff_pend || q.xon_pend || q.ans_pend || q.cr_pend) begin
        n.txd     = 1'b0;
        n.tx_left = `FRAME_LEN;
        n.tx_cnt  = period - 1'b1;
        if (q.xoff_pend) begin
          n.tx_sh     = {1'b1, `CHAR_XOFF};
          n.xoff_pend = 1'b0;
        end else if (q.xon_pend) begin
          n.tx_sh    = {1'b1, `CHAR_XON};
          n.xon_pend = 1'b0;
        end else if (q.ans_pend) begin
          n.tx_sh    = {1'b1, q.ans};
          n.ans_pend = 1'b0;
        end else begin
          n.tx_sh   = {1'b1, `CHAR_CR};
          n.cr_pend = 1'b0;
        end
      end
    end else if (q.tx_cnt == '0) begin
      n.tx_left = q.tx_left - 1'b1;
      n.tx_cnt  = period - 1'b1;
      if (q.tx_left > 4'h1) begin
        n.txd   = q.tx_sh[0]; // RQ9
        n.tx_sh = {1'b1, q.tx_sh[8:1]};
      end
    end else begin
      n.tx_cnt = q.tx_cnt - 1'b1;
    end

    // Command execution
    if (exec) begin
      enter   = !q.remote && q.permit && q.op != `OP_GO_LOCAL && q.op != `OP_PERMIT_OFF; // RQ2
      rem_now = q.remote || enter;
      if (enter) begin
        n.remote = 1'b1; // RQ2
        n.out_on = 1'b0; // RQ3
      end
      case (q.op)
        `OP_GO_LOCAL: n.remote = 1'b0; // RQ6
        `OP_LOCKOUT:  n.lockout = 1'b1; // RQ5
        `OP_PERMIT_OFF: begin
          n.lockout = 1'b0; // RQ7
          n.permit  = 1'b0; // RQ7
          n.remote  = 1'b0; // RQ7
        end
        `OP_PERMIT_ON: n.permit = 1'b1;
        `OP_QUERY: begin
          n.ans      = q.permit ? `ANS_ONE : `ANS_ZERO; // RQ8
          n.ans_pend = 1'b1;
          n.cr_pend  = 1'b1;
        end
        `OP_OUT_ON: begin
          if (rem_now) begin
            n.out_on = 1'b1; // RQ3
          end
        end
        `OP_OUT_OFF: begin
          if (rem_now) begin
            n.out_on = 1'b0;
          end
        end
        `OP_TRIP: begin
          if (rem_now) begin
            n.trip = q.arg; // RQ13
          end
        end
        default: begin
        end
      endcase
    end else if (btn_rise && q.remote && !q.lockout) begin
      n.remote = 1'b0; // RQ4
    end

    // Software flow: XOFF near full, XON once drained
    if (q.flow == FLOW_SOFT) begin
      if (busy && !q.xoff_sent) begin
        n.xoff_pend = 1'b1; // RQ19
        n.xoff_sent = 1'b1;
      end else if (!busy && q.xoff_sent) begin
        n.xon_pend  = 1'b1; // RQ20
        n.xoff_sent = 1'b0;
      end
    end else begin
      n.xoff_sent = 1'b0;
    end
    n.ready_out = (q.flow == FLOW_HARD) ? !busy : 1'b1; // RQ11

    // Trip source from straps, output gating and panel selection
    if (!q.stab[3]) begin
      n.trip_sw = 1'b0; // RQ15
    end else if (!q.stab[4]) begin
      n.trip_sw = 1'b1; // RQ15
    end else begin
      n.trip_sw = n.remote; // RQ13
    end
    n.supply_on = n.out_on && !sd_active; // RQ17
    n.panel_sel = !n.remote;              // RQ18

    // APB slave: pready one cycle into the access phase
    n.rsp = '0;
    if (apb_req.psel && apb_req.penable && !q.rsp.pready) begin
      n.rsp.pready = 1'b1;
      case (apb_req.paddr)
        `REG_CTRL: n.rsp.prdata = {27'h000_0000, q.flow, q.baud_sel};
        `REG_STATUS: begin
          n.rsp.prdata = {25'h000_0000, busy, sd_active, q.trip_sw, q.out_on, q.lockout, q.permit, q.remote};
        end
        `REG_TRIP: n.rsp.prdata = {24'h00_0000, q.trip};
        default:   n.rsp.pslverr = 1'b1;
      endcase
    end
    if (apb_done && apb_req.pwrite && apb_req.paddr == `REG_CTRL) begin
      n.baud_sel = apb_req.pwdata[`CTRL_BAUD_LSB +: 3]; // RQ10
      case (apb_req.pwdata[`CTRL_FLOW_LSB +: 2])
        2'b01: n.flow = FLOW_SOFT;
        2'b10: n.flow = FLOW_HARD;
        default: n.flow = FLOW_NONE; // RQ11
      endcase
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q           <= '0;
      q.s1        <= `SYNC_RESET;
      q.s2        <= `SYNC_RESET;
      q.s3        <= `SYNC_RESET;
      q.stab      <= `SYNC_RESET;
      q.baud_sel  <= `BAUD_RESET; // RQ10
      q.flow      <= FLOW_NONE;   // RQ11
      q.rx_st     <= RX_IDLE;
      q.permit    <= 1'b1;        // RQ1
      q.out_on    <= 1'b1;
      q.supply_on <= 1'b1;
      q.trip      <= `TRIP_DEFAULT; // RQ14
      q.txd       <= 1'b1;
      q.ready_out <= 1'b1;
      q.panel_sel <= 1'b1;
    end else begin
      q <= n;
    end
  end

  // Outputs straight from the state flops
  assign apb_rsp            = q.rsp;
  assign txd                = q.txd;
  assign ready_out          = q.ready_out;
  assign remote_mode        = q.remote;
  assign supply_output_on   = q.supply_on;
  assign trip_from_software = q.trip_sw;
  assign soft_trip_level    = q.trip;
  assign panel_settings     = q.panel_sel;

  // Checks of the mode and link behaviour
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_permit_fall;
    $fell(q.permit) |-> $past(exec && q.op == `OP_PERMIT_OFF);
  endproperty
  a_permit_fall: assert property (p_permit_fall) else $error("permit cleared without permit-off"); // RQ1
  property p_enter_remote;
    exec && !q.remote && q.permit && q.op != `OP_GO_LOCAL && q.op != `OP_PERMIT_OFF && q.op != `OP_OUT_ON
      |=> q.remote && !q.out_on && !q.panel_sel;
  endproperty
  a_enter_remote: assert property (p_enter_remote) else $error("command did not enter remote"); // RQ2
  property p_output_off;
    $rose(q.remote) |-> !q.out_on || $past(q.op) == `OP_OUT_ON;
  endproperty
  a_output_off: assert property (p_output_off) else $error("output left on entering remote"); // RQ3
  property p_button_local;
    btn_rise && q.remote && !q.lockout && !exec |=> !q.remote ##1 q.panel_sel;
  endproperty
  a_button_local: assert property (p_button_local) else $error("button did not return to local"); // RQ4
  property p_lockout_hold;
    btn_rise && q.remote && q.lockout && !exec |=> q.remote;
  endproperty
  a_lockout_hold: assert property (p_lockout_hold) else $error("button acted under lockout"); // RQ5
  property p_go_local;
    exec && q.op == `OP_GO_LOCAL |=> !q.remote && q.lockout == $past(q.lockout);
  endproperty
  a_go_local: assert property (p_go_local) else $error("go-local wrong"); // RQ6
  property p_lockout_clear;
    $fell(q.lockout) |-> $past(exec && q.op == `OP_PERMIT_OFF) && !q.permit && !q.remote;
  endproperty
  a_lockout_clear: assert property (p_lockout_clear) else $error("lockout cleared wrongly"); // RQ7
  property p_query;
    exec && q.op == `OP_QUERY |=> q.ans_pend && q.cr_pend && q.ans == ($past(q.permit) ? `ANS_ONE : `ANS_ZERO);
  endproperty
  a_query: assert property (p_query) else $error("query answer wrong"); // RQ8
  property p_stop_bit;
    q.tx_left == 4'h1 || q.tx_left == 4'h0 |-> q.txd;
  endproperty
  a_stop_bit: assert property (p_stop_bit) else $error("stop or idle level low"); // RQ9
  // A frame starts when the bit counter leaves idle, not at any falling data bit
  property p_start_bit;
    $past(q.tx_left) == 4'h0 && q.tx_left != 4'h0
      |-> !q.txd && q.tx_left == `FRAME_LEN && q.tx_cnt == bit_period(q.baud_sel) - 1'b1;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit timing wrong"); // RQ10
  property p_cr_exec;
    rx_valid && q.rx_sh == `CHAR_CR && q.line_len != 5'h00 |-> exec ##1 q.line_len == 5'h00;
  endproperty
  a_cr_exec: assert property (p_cr_exec) else $error("carriage return not executed"); // RQ12
  property p_trip_change;
    $changed(q.trip) |-> $past(exec && q.op == `OP_TRIP);
  endproperty
  a_trip_change: assert property (p_trip_change) else $error("trip level changed without command"); // RQ14
  property p_trip_source;
    q.stab[3] && q.stab[4] |=> q.trip_sw == q.remote;
  endproperty
  a_trip_source: assert property (p_trip_source) else $error("trip source not following mode"); // RQ15
  property p_shutdown;
    sd_active |=> !q.supply_on;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("output on during shutdown"); // RQ17
  property p_xoff;
    q.flow == FLOW_SOFT && busy && !q.xoff_sent |=> q.xoff_pend && q.xoff_sent;
  endproperty
  a_xoff: assert property (p_xoff) else $error("xoff not queued"); // RQ19
  // A pending xoff is the first character sent once the transmitter is idle
  property p_xoff_first;
    q.tx_left == 4'h0 && q.xoff_pend |=> q.tx_left == `FRAME_LEN && q.tx_sh == {1'b1, `CHAR_XOFF};
  endproperty
  a_xoff_first: assert property (p_xoff_first) else $error("xoff not sent first"); // RQ19
  property p_xon;
    q.flow == FLOW_SOFT && !busy && q.xoff_sent |=> q.xon_pend;
  endproperty
  a_xon: assert property (p_xon) else $error("xon not queued"); // RQ20
  property p_debounce;
    $changed(q.btn_db) |-> $past(q.btn_cnt) == DEBOUNCE_CYCLES - 1;
  endproperty
  a_debounce: assert property (p_debounce) else $error("button accepted before debounce"); // RQ21

  cover property (exec && enter);
  cover property (exec && q.op == `OP_QUERY);
  cover property (btn_rise && q.remote && q.lockout);
  cover property (q.flow == FLOW_SOFT && q.xoff_pend);
endmodule

// File: design/rlm_defs.svh
// Purpose: Constants of the remote/local mode control block
// Assumes: 10 MHz pclk; APB word registers
// Notes:   Definitions only
`ifndef RLM_DEFS_SVH
`define RLM_DEFS_SVH

// Clock and serial timing
`define CLK_HZ          10_000_000
`define BAUD_MIN        75
`define BIT_CYCLES_MIN  (`CLK_HZ / `BAUD_MIN)
`define DEBOUNCE_US     5000
`define DEBOUNCE_CYCLES (`CLK_HZ / 1_000_000 * `DEBOUNCE_US)
`define CNT_W           18
`define DEB_W           16

// Register offsets
`define REG_CTRL   12'h000
`define REG_STATUS 12'h004
`define REG_TRIP   12'h008

// Control fields and reset values
`define CTRL_BAUD_LSB   0
`define CTRL_FLOW_LSB   3
`define BAUD_RESET      3'h7
`define TRIP_DEFAULT    8'h6E
`define SYNC_RESET      6'h39

// Characters
`define CHAR_CR   8'h0D
`define CHAR_XOFF 8'h13
`define CHAR_XON  8'h11
`define ANS_ONE   8'h31
`define ANS_ZERO  8'h30

// Command opcodes (first character of a line)
`define OP_GO_LOCAL   8'h47
`define OP_LOCKOUT    8'h4B
`define OP_PERMIT_OFF 8'h50
`define OP_PERMIT_ON  8'h45
`define OP_QUERY      8'h3F
`define OP_OUT_ON     8'h4F
`define OP_OUT_OFF    8'h46
`define OP_TRIP       8'h54

// Line buffer limits and serial frame length
`define LINE_MAX  5'h10
`define LINE_HIGH 5'h0E
`define FRAME_LEN 4'hA

`endif

// File: design/rlm_pkg.sv
// Purpose: Types of the remote/local mode control block
// Assumes: rlm_defs.svh gives the widths
// Notes:   State is one packed struct
`include "rlm_defs.svh"
package rlm_pkg;

  typedef enum logic [1:0] {RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_STOP = 2'b11} rx_state_e;
  typedef enum logic [1:0] {FLOW_NONE = 2'b00, FLOW_SOFT = 2'b01, FLOW_HARD = 2'b10} flow_e;

  typedef struct packed {
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic [5:0]          s1;
    logic [5:0]          s2;
    logic [5:0]          s3;
    logic [5:0]          stab;
    logic                btn_db;
    logic                sd_db;
    logic [`DEB_W-1:0]   btn_cnt;
    logic [`DEB_W-1:0]   sd_cnt;
    logic [2:0]          baud_sel;
    flow_e               flow;
    rx_state_e           rx_st;
    logic [`CNT_W-1:0]   rx_cnt;
    logic [2:0]          rx_bit;
    logic [7:0]          rx_sh;
    logic [8:0]          tx_sh;
    logic [`CNT_W-1:0]   tx_cnt;
    logic [3:0]          tx_left;
    logic [4:0]          line_len;
    logic [7:0]          op;
    logic [7:0]          arg;
    logic                xoff_sent;
    logic                xoff_pend;
    logic                xon_pend;
    logic [7:0]          ans;
    logic                ans_pend;
    logic                cr_pend;
    logic                remote;
    logic                permit;
    logic                lockout;
    logic                out_on;
    logic [7:0]          trip;
    logic                txd;
    logic                ready_out;
    logic                supply_on;
    logic                trip_sw;
    logic                panel_sel;
    apb_rsp_s            rsp;
  } state_s;

endpackage

// File: tb/host_link.sv
// Purpose: Host computer side of the serial command link
// Assumes: Bit period given in pclk cycles
// Notes:   Sends 8N1 frames on demand and decodes every reply frame
module host_link #(
  parameter int BITP = 8
) (
  input  wire logic       pclk,
  input  wire logic       txd,
  output logic            rxd,
  output logic [7:0]      got,
  output logic            got_stop,
  output logic            got_stb
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh;
  int         bitp = BITP;

  // Line idles at mark level, no flow control on the host side
  initial begin
    rxd = 1'b1;
    got = 8'h00;
    got_stop = 1'b0;
    got_stb = 1'b0;
    sh = 8'h00;
  end

  // Start bit, eight data bits LSB first, one stop bit, no parity
  task automatic send(input logic [7:0] c);
    logic [9:0] fr;
    fr = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd <= fr[i];
      repeat (bitp) @(posedge pclk);
    end
  endtask

  // Replies are sampled mid-bit on the falling edge, away from txd updates
  always begin
    @(negedge txd);
    repeat (bitp / 2) @(negedge pclk);
    for (int i = 0; i < 8; i++) begin
      repeat (bitp) @(negedge pclk);
      sh[i] = txd;
    end
    repeat (bitp) @(negedge pclk);
    got <= sh;
    got_stop <= txd;
    got_stb <= 1'b1;
    @(negedge pclk);
    got_stb <= 1'b0;
  end
endmodule

// File: tb/remote_local_mode_control_bench.sv
// Purpose: Self-checking bench of the remote/local mode control block
// Assumes: Bit period 8 cycles (1024 >> 7), debounce of 4 cycles
// Notes:   APB answers and serial replies are checked against queued notes
`include "rlm_defs.svh"
module remote_local_mode_control_bench import rlm_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BITP  = 8;
  localparam int LIMIT = 20000;
  logic        pclk, presetn, rxd, txd, ready_out, local_button, shutdown_in;
  logic        local_trip_strap, remote_trip_strap, shutdown_polarity_strap;
  logic        remote_mode, supply_output_on, trip_from_software, panel_settings, got_stop, got_stb;
  logic [7:0]  soft_trip_level, got, v;
  logic [31:0] seed;
  apb_req_s    req;
  apb_rsp_s    rsp;
  logic [32:0] exp_rd[$];
  logic [8:0]  exp_tx[$];
  int          n_checks, n_mismatch, cycles;

  remote_local_mode_control #(.BIT_CYCLES_MIN(1024), .DEBOUNCE_CYCLES(4)) i_dut (
    .pclk, .presetn, .apb_req(req), .apb_rsp(rsp), .rxd, .txd, .ready_out, .local_button, .shutdown_in,
    .local_trip_strap, .remote_trip_strap, .shutdown_polarity_strap, .remote_mode, .supply_output_on,
    .trip_from_software, .soft_trip_level, .panel_settings
  );
  host_link #(.BITP(BITP)) i_host (.pclk, .txd, .rxd, .got, .got_stop, .got_stb);

  // Clock of 100 ns
  always #50 pclk = ~pclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic fail(input string m);
    n_mismatch++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk_level(input logic [7:0] g, input logic [7:0] e, input string m);
    n_checks++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_read(input logic [32:0] g);
    n_checks++;
    if (exp_rd.size() == 0) fail("apb answer not expected");
    else if (g !== exp_rd.pop_front()) fail("apb answer");
  endtask
  task automatic chk_char(input logic [8:0] g);
    n_checks++;
    if (exp_tx.size() == 0) fail("reply not expected");
    else if (g !== exp_tx.pop_front()) fail("reply char");
  endtask
  // Mode outputs: remote, supply on, trip from software, panel settings
  task automatic lv(input logic [3:0] e);
    chk_level({4'h0, remote_mode, supply_output_on, trip_from_software, panel_settings}, {4'h0, e}, "mode");
  endtask

  // One APB transfer; waits for pready, then releases and idles a cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] e);
    exp_rd.push_back(wr ? {e[32], 32'h0000_0000} : e);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000, {1'b0, e});
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {1'b0, d});
  endtask

  // Last character of a line, then the terminator
  task automatic cmd(input logic [7:0] op);
    i_host.send(op);
    i_host.send(`CHAR_CR);
    repeat (6) @(posedge pclk);
  endtask
  task automatic fill(input int n);
    for (int i = 0; i < n; i++) i_host.send(8'h41 + 8'(i));
  endtask
  task automatic press();
    local_button <= 1'b1;
    repeat (30) @(posedge pclk);
    local_button <= 1'b0;
    repeat (30) @(posedge pclk);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic done(input string m);
    $display("test done: %s", m);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Result watchers take the oldest note for each answer
  always @(posedge pclk) begin
    if (rsp.pready === 1'b1) chk_read({rsp.pslverr, req.pwrite ? 32'h0000_0000 : rsp.prdata});
  end
  always @(posedge got_stb) chk_char({got_stop, got});

  // Hang guard
  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail("timeout");
      end_sim();
    end
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    local_button = 1'b0;
    shutdown_in = 1'b0;
    local_trip_strap = 1'b1;
    remote_trip_strap = 1'b1;
    shutdown_polarity_strap = 1'b1;
    req = '0;
    seed = 32'hf78d_efa9;
    n_checks = 0;
    n_mismatch = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    lv(4'b0101);
    chk_level(soft_trip_level, 8'h6E, "trip default");
    rd(`REG_STATUS, 32'h0000_000A);
    rd(`REG_CTRL, 32'h0000_0007);
    rd(`REG_TRIP, 32'h0000_006E);
    apb(1'b0, 12'h00C, 32'h0000_0000, {1'b1, 32'h0000_0000});
    wr(`REG_STATUS, 32'h0000_00FF);
    rd(`REG_STATUS, 32'h0000_000A);
    done("reset and registers");
    exp_tx.push_back({1'b1, `ANS_ONE});
    exp_tx.push_back({1'b1, `CHAR_CR});
    cmd(`OP_QUERY);
    lv(4'b1010);
    cmd(`OP_OUT_ON);
    lv(4'b1110);
    seed = xs(seed);
    v = {1'b1, seed[6:0]};
    i_host.send(`OP_TRIP);
    cmd(v);
    chk_level(soft_trip_level, v, "trip level");
    rd(`REG_TRIP, {24'h00_0000, v});
    done("remote entry");
    cmd(`OP_LOCKOUT);
    press();
    lv(4'b1110);
    rd(`REG_STATUS, 32'h0000_001F);
    cmd(`OP_GO_LOCAL);
    lv(4'b0101);
    rd(`REG_STATUS, 32'h0000_000E);
    cmd(8'h58);
    lv(4'b1010);
    press();
    lv(4'b1010);
    cmd(`OP_PERMIT_OFF);
    lv(4'b0001);
    rd(`REG_STATUS, 32'h0000_0000);
    exp_tx.push_back({1'b1, `ANS_ZERO});
    exp_tx.push_back({1'b1, `CHAR_CR});
    cmd(`OP_QUERY);
    lv(4'b0001);
    cmd(`OP_PERMIT_ON);
    cmd(`OP_OUT_ON);
    lv(4'b1110);
    press();
    lv(4'b0101);
    done("lockout and permit");
    local_trip_strap <= 1'b0;
    wt(8);
    cmd(8'h58);
    lv(4'b1000);
    local_trip_strap <= 1'b1;
    remote_trip_strap <= 1'b0;
    cmd(`OP_GO_LOCAL);
    chk_level({7'h00, trip_from_software}, 8'h01, "software only");
    remote_trip_strap <= 1'b1;
    cmd(`OP_OUT_ON);
    lv(4'b1110);
    cmd(`OP_OUT_OFF);
    lv(4'b1010);
    cmd(`OP_OUT_ON);
    lv(4'b1110);
    done("trip straps");
    shutdown_in <= 1'b1;
    wt(30);
    lv(4'b1010);
    shutdown_polarity_strap <= 1'b0;
    wt(30);
    lv(4'b1110);
    shutdown_in <= 1'b0;
    wt(30);
    lv(4'b1010);
    shutdown_polarity_strap <= 1'b1;
    wt(30);
    lv(4'b1110);
    done("shutdown");
    wr(`REG_CTRL, 32'h0000_000F);
    exp_tx.push_back({1'b1, `CHAR_XOFF});
    exp_tx.push_back({1'b1, `CHAR_XON});
    fill(13);
    cmd(8'h4E);
    wr(`REG_CTRL, 32'h0000_0017);
    rd(`REG_CTRL, 32'h0000_0017);
    fill(14);
    wt(4);
    chk_level({7'h00, ready_out}, 8'h00, "ready while full");
    i_host.send(`CHAR_CR);
    wt(6);
    chk_level({7'h00, ready_out}, 8'h01, "ready after line");
    wr(`REG_CTRL, 32'h0000_001F);
    fill(14);
    wt(4);
    chk_level({7'h00, ready_out}, 8'h01, "ready without flow");
    i_host.send(`CHAR_CR);
    done("flow control");
    // Slower rate on both ends: query and reply at 16 cycles a bit
    wt(4);
    wr(`REG_CTRL, 32'h0000_0006);
    i_host.bitp = 2 * BITP;
    exp_tx.push_back({1'b1, `ANS_ONE});
    exp_tx.push_back({1'b1, `CHAR_CR});
    cmd(`OP_QUERY);
    done("bit rate");
    for (int k = 0; k < 2000 && exp_tx.size() != 0; k++) @(posedge pclk);
    if (exp_tx.size() != 0 || exp_rd.size() != 0) fail("answers missing");
    end_sim();
  end
endmodule
